// File: core/sclsb_regs.vh
// register offsets, field positions and constants of the config loader / sideband block
`ifndef SCLSB_REGS_VH
`define SCLSB_REGS_VH
// configuration register byte offsets
`define SCLSB_OFS_LINK_TIMERS 12'h070
`define SCLSB_OFS_PM_PHY_CTRL 12'h074
`define SCLSB_OFS_PHY_WORD3 12'h080
`define SCLSB_OFS_PHY_WORD5 12'h088
`define SCLSB_OFS_TL_CTRL 12'h08c
`define SCLSB_OFS_SLOT_CAP 12'h0d4
`define SCLSB_OFS_VC1_CAP 12'h15c
`define SCLSB_OFS_VC1_CTRL 12'h160
// memory word addresses
`define SCLSB_MEM_PM_P1 8'h82
`define SCLSB_MEM_PM_P2 8'h84
`define SCLSB_MEM_SLOT_LO_P1 8'h92
`define SCLSB_MEM_SLOT_LO_P2 8'h94
`define SCLSB_MEM_SLOT_HI_P1 8'ha2
`define SCLSB_MEM_SLOT_HI_P2 8'ha4
`define SCLSB_MEM_PHY3_LO 8'hb0
`define SCLSB_MEM_PHY3_HI 8'hc0
`define SCLSB_MEM_REPLAY 8'hd0
`define SCLSB_MEM_ACK 8'he0
`define SCLSB_MEM_VC1 8'hf0
`define SCLSB_MEM_LAST 8'hf4
// field positions
`define SCLSB_PM_SRC_LSB 0
`define SCLSB_PM_DST_LSB 8
`define SCLSB_RXPOL_SRC 6
`define SCLSB_RXPOL_DST 14
`define SCLSB_VGA_SRC 7
`define SCLSB_VGA_DST 31
`define SCLSB_REPLAY_MSB 12
`define SCLSB_TSCTR_SRC_LSB 13
`define SCLSB_TSCTR_DST_LSB 24
`define SCLSB_ACK_MSB 30
`define SCLSB_ACK_LSB 16
`define SCLSB_VC1_SLOT_DST_LSB 16
// sideband slave address, upper four bits fixed
`define SCLSB_SB_ADDR_HI 4'hd
// reset values
`define SCLSB_RST_WORD 32'h00000000
`endif

// File: core/sclsb_sync.v
// two flip-flop synchroniser for one pin
`timescale 1ns/100ps
module sclsb_sync (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire din,
  output wire dout
);
  reg meta_reg;
  reg sync_reg;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
    end else if (ce) begin
      meta_reg <= din;
      sync_reg <= meta_reg;
    end
  end
  assign dout = sync_reg;
endmodule // sclsb_sync

// File: core/sclsb_port_regs.v
// one port's set of loadable configuration registers
`timescale 1ns/100ps
`include "sclsb_regs.vh"
module sclsb_port_regs (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire [2:0] sel,
  input wire [31:0] wr_mask,
  input wire [31:0] wr_data,
  input wire wr_en,
  output reg [31:0] link_timers_reg,
  output reg [31:0] power_mgmt_phy_control_reg,
  output reg [31:0] phy_control_word_three_reg,
  output reg [31:0] phy_control_word_five_reg,
  output reg [31:0] transaction_layer_control_reg,
  output reg [31:0] slot_capabilities_reg,
  output reg [31:0] vc1_resource_capability_reg,
  output reg [31:0] vc1_resource_control_reg
);
  // masked merge: only bits set in wr_mask change
  function [31:0] merge;
    input [31:0] old;
    input [31:0] m;
    input [31:0] d;
    begin
      merge = (old & ~m) | (d & m);
    end
  endfunction
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_timers_reg <= `SCLSB_RST_WORD;
      power_mgmt_phy_control_reg <= `SCLSB_RST_WORD;
      phy_control_word_three_reg <= `SCLSB_RST_WORD;
      phy_control_word_five_reg <= `SCLSB_RST_WORD;
      transaction_layer_control_reg <= `SCLSB_RST_WORD;
      slot_capabilities_reg <= `SCLSB_RST_WORD;
      vc1_resource_capability_reg <= `SCLSB_RST_WORD;
      vc1_resource_control_reg <= `SCLSB_RST_WORD;
    end else if (ce && wr_en) begin
      case (sel)
        3'h0: link_timers_reg <= merge(link_timers_reg, wr_mask, wr_data);
        3'h1: power_mgmt_phy_control_reg <= merge(power_mgmt_phy_control_reg, wr_mask, wr_data);
        3'h2: phy_control_word_three_reg <= merge(phy_control_word_three_reg, wr_mask, wr_data);
        3'h3: phy_control_word_five_reg <= merge(phy_control_word_five_reg, wr_mask, wr_data);
        3'h4: transaction_layer_control_reg <=
          merge(transaction_layer_control_reg, wr_mask, wr_data);
        3'h5: slot_capabilities_reg <= merge(slot_capabilities_reg, wr_mask, wr_data);
        3'h6: vc1_resource_capability_reg <=
          merge(vc1_resource_capability_reg, wr_mask, wr_data);
        default: vc1_resource_control_reg <= merge(vc1_resource_control_reg, wr_mask, wr_data);
      endcase
    end
  end
endmodule // sclsb_port_regs

// File: core/sclsb_top.v
// configuration memory loader and sideband slave for three switch ports
// Behaviour
// - port 1 pm word bits 5:0 go to 74h bits 13:8
// - pm word bit 6 goes to 74h bit 14
// - pm word bit 7 goes to 70h bit 31
// - pm word bits 15:8 go to 88h bits 31:24
// - port 2 uses word 84h with the same layout
// - slot capability low half from words 92h and 94h
// - slot capability high half from words a2h and a4h
// - phy word three low half from words b0h, b2h, b4h
// - phy word three high half from words c0h, c2h, c4h
// - replay time-out 12:0 of 70h from words d0h, d2h, d4h
// - replay word bits 14:13 go to 8ch bits 25:24
// - ack latency 30:16 of 70h from words e0h, e2h, e4h
// - vc1 max slot 15ch bits 22:16 from word bits 6:0
// - traffic class map 160h bits 7:0 from word bits 15:8
// - sideband is slave only, never starts a transfer
// - sideband master reads and writes every rw register
// - sideband may also write read-only loadable registers
// - slave address bits 6:3 are 1101, bits 2:0 the strap pins
// - data pin is two-way, open drain; clock pin is input only, never driven
`timescale 1ns/100ps
`include "sclsb_regs.vh"
module sclsb_top (
  input wire sys_clk,
  input wire reset_n,
  input wire clk_en,
  output reg mem_req,
  output reg [7:0] mem_addr,
  input wire mem_ack,
  input wire mem_valid,
  input wire [15:0] mem_data,
  output wire load_done,
  input wire sideband_clock_pin_in,
  output wire sideband_clock_pin_out,
  output wire sideband_clock_pin_oe,
  input wire sideband_data_pin_in,
  output wire sideband_data_pin_out,
  output reg sideband_data_pin_oe,
  input wire [2:0] addr_strap,
  output wire [3*32*8-1:0] port_regs_flat
);
  // ************************************************************
  // reset release
  // ************************************************************
  reg rst_meta_reg;
  reg rst_sync_reg;
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  wire rst_n = rst_sync_reg;
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  wire scl_s;
  wire sda_s;
  sclsb_sync u_scl (.clk(sys_clk), .rst_n(rst_n), .ce(clk_en),
    .din(sideband_clock_pin_in), .dout(scl_s));
  sclsb_sync u_sda (.clk(sys_clk), .rst_n(rst_n), .ce(clk_en),
    .din(sideband_data_pin_in), .dout(sda_s));
  reg scl_d_reg;
  reg sda_d_reg;
  reg [5:0] strap_reg;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      strap_reg <= 6'h00;
    end else if (clk_en) begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      strap_reg <= {strap_reg[2:0], addr_strap}; // two stages, the straps are pins
    end
  end
  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  wire start_cond = scl_s & scl_d_reg & ~sda_s & sda_d_reg;
  wire stop_cond = scl_s & scl_d_reg & sda_s & ~sda_d_reg;
  wire [6:0] my_addr = {`SCLSB_SB_ADDR_HI, strap_reg[5:3]};
  // slave only: clock pin is never pulled, no clock stretching
  assign sideband_clock_pin_out = 1'b0;
  assign sideband_clock_pin_oe = 1'b0;
  assign sideband_data_pin_out = 1'b0;
  // ************************************************************
  // shared register write port
  // ************************************************************
  reg [2:0] wr_port;
  reg [2:0] wr_sel;
  reg [31:0] wr_mask;
  reg [31:0] wr_data;
  reg wr_en;
  wire [255:0] regs_p [0:2];
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_port
      sclsb_port_regs u_regs (
        .clk(sys_clk), .rst_n(rst_n), .ce(clk_en), .sel(wr_sel),
        .wr_mask(wr_mask), .wr_data(wr_data), .wr_en(wr_en & wr_port[gi]),
        .link_timers_reg(regs_p[gi][31:0]),
        .power_mgmt_phy_control_reg(regs_p[gi][63:32]),
        .phy_control_word_three_reg(regs_p[gi][95:64]),
        .phy_control_word_five_reg(regs_p[gi][127:96]),
        .transaction_layer_control_reg(regs_p[gi][159:128]),
        .slot_capabilities_reg(regs_p[gi][191:160]),
        .vc1_resource_capability_reg(regs_p[gi][223:192]),
        .vc1_resource_control_reg(regs_p[gi][255:224]));
      assign port_regs_flat[gi*256 +: 256] = regs_p[gi];
    end
  endgenerate
  // ************************************************************
  // memory loader
  // ************************************************************
  localparam LD_REQ = 3'b001;
  localparam LD_WAIT = 3'b010;
  localparam LD_DONE = 3'b100;
  reg [2:0] ld_state_reg;
  reg [15:0] ld_word_reg;
  reg [7:0] ld_addr_reg;
  reg [1:0] ld_step_reg;
  reg ld_apply_reg;
  assign load_done = ld_state_reg[2];
  // walk order: port pairs 82h to a4h, then groups of three ending on x4h
  wire [7:0] ld_next_addr = (ld_addr_reg == 8'h84) ? 8'h92 : (ld_addr_reg == 8'h94) ? 8'ha2 :
    (ld_addr_reg[3:0] == 4'h4) ? {ld_addr_reg[7:4] + 4'h1, 4'h0} : ld_addr_reg + 8'h02;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ld_state_reg <= LD_REQ;
      mem_req <= 1'b0;
      mem_addr <= `SCLSB_MEM_PM_P1;
      ld_addr_reg <= `SCLSB_MEM_PM_P1;
      ld_word_reg <= 16'h0000;
      ld_step_reg <= 2'h0;
      ld_apply_reg <= 1'b0;
    end else if (clk_en) begin
      case (ld_state_reg)
        LD_REQ: begin
          if (!ld_apply_reg) begin
            mem_req <= 1'b1;
            mem_addr <= ld_addr_reg;
            ld_state_reg <= LD_WAIT;
          end else begin
            ld_step_reg <= ld_step_reg + 2'h1;
          end
          if (ld_apply_reg && (ld_step_reg == 2'h2 ||
              !(ld_addr_reg == `SCLSB_MEM_PM_P1 || ld_addr_reg == `SCLSB_MEM_PM_P2 ||
                ld_addr_reg[7:4] == 4'hd || ld_addr_reg[7:4] == 4'hf))) begin
            ld_step_reg <= 2'h0;
            ld_apply_reg <= 1'b0;
            if (ld_addr_reg == `SCLSB_MEM_LAST) begin
              ld_state_reg <= LD_DONE;
            end else begin
              ld_addr_reg <= ld_next_addr;
            end
          end
        end
        LD_WAIT: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            // no valid image: field keeps its default
            if (mem_valid) begin
              ld_word_reg <= mem_data;
              ld_apply_reg <= 1'b1;
              ld_state_reg <= LD_REQ;
            end else if (ld_addr_reg == `SCLSB_MEM_LAST) begin
              ld_state_reg <= LD_DONE;
            end else begin
              ld_addr_reg <= ld_next_addr;
              ld_state_reg <= LD_REQ;
            end
          end
        end
        LD_DONE: begin
          mem_req <= 1'b0;
        end
        default: ld_state_reg <= LD_REQ;
      endcase
    end
  end
  // ************************************************************
  // sideband slave
  // ************************************************************
  // frame: addr+w, offset hi, offset lo, then 4 data bytes msb first (write)
  // or addr+w, offset hi, offset lo, restart, addr+r, 4 bytes out (read)
  localparam SB_IDLE = 4'b0001;
  localparam SB_RECV = 4'b0010;
  localparam SB_ACK = 4'b0100;
  localparam SB_SEND = 4'b1000;
  reg [3:0] sb_state_reg;
  reg [7:0] sb_shift_reg;
  reg [3:0] sb_bit_reg;
  reg [2:0] sb_byte_reg;
  reg sb_rd_reg;
  reg sb_nack_reg;
  reg [15:0] sb_ofs_reg;
  reg [31:0] sb_data_reg;
  reg sb_commit_reg;
  wire sb_master_ack = ~sda_s;
  function [2:0] ofs_sel;
    input [11:0] o;
    begin
      case (o)
        `SCLSB_OFS_LINK_TIMERS: ofs_sel = 3'h0;
        `SCLSB_OFS_PM_PHY_CTRL: ofs_sel = 3'h1;
        `SCLSB_OFS_PHY_WORD3: ofs_sel = 3'h2;
        `SCLSB_OFS_PHY_WORD5: ofs_sel = 3'h3;
        `SCLSB_OFS_TL_CTRL: ofs_sel = 3'h4;
        `SCLSB_OFS_SLOT_CAP: ofs_sel = 3'h5;
        `SCLSB_OFS_VC1_CAP: ofs_sel = 3'h6;
        default: ofs_sel = 3'h7;
      endcase
    end
  endfunction
  wire [1:0] sb_port = sb_ofs_reg[13:12];
  wire [2:0] sb_sel = ofs_sel(sb_ofs_reg[11:0]);
  wire sb_hit = (sb_port != 2'h3) &&
    (sb_sel != 3'h7 || sb_ofs_reg[11:0] == `SCLSB_OFS_VC1_CTRL);
  wire [255:0] sb_port_regs = (sb_port == 2'h0) ? regs_p[0] :
    (sb_port == 2'h1) ? regs_p[1] : regs_p[2];
  wire [31:0] sb_rd_word = sb_hit ? sb_port_regs[sb_sel*32 +: 32] : 32'h00000000;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sb_state_reg <= SB_IDLE;
      sb_shift_reg <= 8'h00;
      sb_bit_reg <= 4'h0;
      sb_byte_reg <= 3'h0;
      sb_rd_reg <= 1'b0;
      sb_nack_reg <= 1'b0;
      sb_ofs_reg <= 16'h0000;
      sb_data_reg <= 32'h00000000;
      sb_commit_reg <= 1'b0;
      sideband_data_pin_oe <= 1'b0;
    end else if (clk_en) begin
      sb_commit_reg <= 1'b0;
      if (start_cond) begin
        sb_state_reg <= load_done ? SB_RECV : SB_IDLE;
        sb_bit_reg <= 4'h0;
        sb_byte_reg <= 3'h0;
        sideband_data_pin_oe <= 1'b0;
      end else if (stop_cond) begin
        sb_state_reg <= SB_IDLE;
        sideband_data_pin_oe <= 1'b0;
        sb_commit_reg <= ~sb_rd_reg && sb_byte_reg == 3'h7;
      end else begin
        case (sb_state_reg)
          SB_IDLE: sideband_data_pin_oe <= 1'b0;
          SB_RECV: if (scl_rise) begin
            sb_shift_reg <= {sb_shift_reg[6:0], sda_s};
            sb_bit_reg <= sb_bit_reg + 4'h1;
          end else if (scl_fall && sb_bit_reg == 4'h8) begin
            sb_bit_reg <= 4'h0;
            sb_nack_reg <= 1'b0;
            if (sb_byte_reg == 3'h0) begin
              sb_rd_reg <= sb_shift_reg[0];
              if (sb_shift_reg[7:1] != my_addr) begin
                sb_state_reg <= SB_IDLE;
                sb_nack_reg <= 1'b1;
              end
            end else if (sb_byte_reg == 3'h1) begin
              sb_ofs_reg[15:8] <= sb_shift_reg;
            end else if (sb_byte_reg == 3'h2) begin
              sb_ofs_reg[7:0] <= sb_shift_reg;
            end else begin
              sb_data_reg <= {sb_data_reg[23:0], sb_shift_reg};
            end
            if (sb_shift_reg[7:1] == my_addr || sb_byte_reg != 3'h0) begin
              sideband_data_pin_oe <= 1'b1;
              sb_state_reg <= SB_ACK;
            end
          end
          SB_ACK: if (scl_fall) begin
            sideband_data_pin_oe <= 1'b0;
            if (sb_byte_reg == 3'h0 && sb_rd_reg) begin
              sb_data_reg <= sb_rd_word;
              sideband_data_pin_oe <= ~sb_rd_word[31];
              sb_byte_reg <= 3'h3;
              sb_state_reg <= SB_SEND;
            end else begin
              sb_byte_reg <= (sb_byte_reg == 3'h7) ? 3'h7 : sb_byte_reg + 3'h1;
              sb_state_reg <= SB_RECV;
            end
          end
          SB_SEND: if (scl_fall) begin
            if (sb_bit_reg == 4'h7) begin
              sideband_data_pin_oe <= 1'b0;
              sb_bit_reg <= 4'h8;
            end else if (sb_bit_reg == 4'h8) begin
              sb_bit_reg <= 4'h0;
              sb_data_reg <= {sb_data_reg[30:0], 1'b0};
              sideband_data_pin_oe <= sb_nack_reg ? 1'b0 : ~sb_data_reg[30];
              if (sb_nack_reg) sb_state_reg <= SB_IDLE;
            end else begin
              sb_bit_reg <= sb_bit_reg + 4'h1;
              sb_data_reg <= {sb_data_reg[30:0], 1'b0};
              sideband_data_pin_oe <= ~sb_data_reg[30];
            end
          end else if (scl_rise && sb_bit_reg == 4'h8) begin
            sb_nack_reg <= ~sb_master_ack;
          end
          default: sb_state_reg <= SB_IDLE;
        endcase
      end
    end
  end
  // ************************************************************
  // write arbitration: loader during load, sideband afterwards
  // ************************************************************
  wire [15:0] w = ld_word_reg;
  wire [7:0] a = ld_addr_reg;
  reg [1:0] ld_pidx;
  always @* begin
    ld_pidx = 2'h0;
    if (a == `SCLSB_MEM_PM_P1 || a[3:0] == 4'h2) ld_pidx = 2'h1;
    if (a == `SCLSB_MEM_PM_P2 || a[3:0] == 4'h4) ld_pidx = 2'h2;
    wr_en = 1'b0;
    wr_port = 3'h0;
    wr_sel = 3'h0;
    wr_mask = 32'h00000000;
    wr_data = 32'h00000000;
    if (ld_apply_reg && ld_state_reg == LD_REQ) begin
      wr_en = ~(ld_step_reg == 2'h2 && a[7:4] != 4'h8);
      wr_port = 3'h1 << ld_pidx;
      if (a == `SCLSB_MEM_PM_P1 || a == `SCLSB_MEM_PM_P2) begin
        wr_sel = (ld_step_reg == 2'h0) ? 3'h1 : (ld_step_reg == 2'h1) ? 3'h0 : 3'h3;
        wr_mask = (ld_step_reg == 2'h0) ? 32'h00007f00 :
          (ld_step_reg == 2'h1) ? 32'h80000000 : 32'hff000000;
        wr_data = {w[15:8], 24'h0};
        if (ld_step_reg == 2'h0) wr_data = {17'h0, w[6:0], 8'h00};
        if (ld_step_reg == 2'h1) wr_data = {w[`SCLSB_VGA_SRC], 31'h0};
      end else if (a[7:4] == 4'h9 || a[7:4] == 4'ha) begin
        wr_sel = 3'h5;
        wr_mask = a[5] ? 32'hffff0000 : 32'h0000ffff;
        wr_data = {w, w};
      end else if (a[7:4] == 4'hb || a[7:4] == 4'hc) begin
        wr_sel = 3'h2;
        wr_mask = a[6] ? 32'hffff0000 : 32'h0000ffff;
        wr_data = {w, w};
      end else if (a[7:4] == 4'hd) begin
        wr_sel = (ld_step_reg == 2'h0) ? 3'h0 : 3'h4;
        wr_mask = (ld_step_reg == 2'h0) ? 32'h00001fff : 32'h03000000;
        wr_data = (ld_step_reg == 2'h0) ? {19'h0, w[`SCLSB_REPLAY_MSB:0]} :
          {6'h0, w[14:13], 24'h0};
      end else if (a[7:4] == 4'he) begin
        wr_sel = 3'h0;
        wr_mask = 32'h7fff0000;
        wr_data = {1'b0, w[14:0], 16'h0};
      end else begin
        wr_sel = (ld_step_reg == 2'h0) ? 3'h6 : 3'h7;
        wr_mask = (ld_step_reg == 2'h0) ? 32'h007f0000 : 32'h000000ff;
        wr_data = (ld_step_reg == 2'h0) ? {9'h0, w[6:0], 16'h0} :
          {24'h0, w[15:8]};
      end
    end else if (sb_commit_reg && sb_hit) begin
      wr_en = 1'b1; // read-only loadable registers included
      wr_port = 3'h1 << sb_port;
      wr_sel = sb_sel;
      wr_mask = 32'hffffffff;
      wr_data = sb_data_reg;
    end
  end
endmodule // sclsb_top

// File: testbench/sclsb_mem_model.sv
// behavioural configuration memory word port answering the loader
`timescale 1ns/100ps
module sclsb_mem_model (
  input wire logic sys_clk,
  input wire logic mem_req,
  input wire logic [7:0] mem_addr,
  output logic mem_ack,
  output logic mem_valid,
  output logic [15:0] mem_data
);
  initial begin
    mem_ack = 1'b0;
    mem_valid = 1'b0;
    mem_data = 16'h0;
    forever begin
      @(posedge sys_clk);
      if (mem_req === 1'b1) begin
        repeat ($urandom_range(0, 3)) @(posedge sys_clk);
        #1;
        mem_ack = 1'b1;
        // word 94h has no valid image, so its field keeps its reset value
        mem_valid = (mem_addr !== 8'h94);
        mem_data = {mem_addr ^ 8'h3c, mem_addr};
        @(posedge sys_clk);
        #1;
        mem_ack = 1'b0;
        mem_valid = 1'b0;
        mem_data = ~mem_data;
      end
    end
  end
endmodule // sclsb_mem_model

// File: testbench/sclsb_top_properties.sv
// assertions on the ports of the config loader and sideband slave
`timescale 1ns/100ps
module sclsb_props (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic mem_req,
  input wire logic [7:0] mem_addr,
  input wire logic mem_ack,
  input wire logic mem_valid,
  input wire logic [15:0] mem_data,
  input wire logic load_done,
  input wire logic sideband_clock_pin_in,
  input wire logic sideband_clock_pin_oe,
  input wire logic sideband_data_pin_out,
  input wire logic sideband_data_pin_oe,
  input wire logic [767:0] port_regs_flat
);
  logic [15:0] pm_cap;
  always @(posedge sys_clk) begin
    if (mem_req && mem_ack && mem_valid && mem_addr == 8'h82) begin
      pm_cap <= mem_data;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  property p_clk_quiet; sideband_clock_pin_oe == 1'b0; endproperty
  a_clk_quiet: assert property (p_clk_quiet) else $error("clock pin driven");
  property p_open_drain; sideband_data_pin_out == 1'b0; endproperty
  a_open_drain: assert property (p_open_drain) else $error("data pin driven high");
  property p_req_holds; clk_en && mem_req && !mem_ack |=> mem_req && $stable(mem_addr); endproperty
  a_req_holds: assert property (p_req_holds) else $error("word request dropped");
  property p_quiet_load; !load_done |-> !sideband_data_pin_oe; endproperty
  a_quiet_load: assert property (p_quiet_load) else $error("answer before load");
  property p_done_sticky; load_done |=> load_done; endproperty
  a_done_sticky: assert property (p_done_sticky) else $error("load done fell");
  property p_no_req_after; load_done |-> !mem_req; endproperty
  a_no_req_after: assert property (p_no_req_after) else $error("request after load");
  property p_oe_clk_low; $changed(sideband_data_pin_oe) |-> !sideband_clock_pin_in; endproperty
  a_oe_clk_low: assert property (p_oe_clk_low) else $error("data moved, clock high");
  property p_pm_load;
    mem_req && mem_ack && mem_valid && mem_addr == 8'h82 |=> ##[0:3]
      {port_regs_flat[383:376], port_regs_flat[287], port_regs_flat[302:296]} == pm_cap;
  endproperty
  a_pm_load: assert property (p_pm_load) else $error("pm word misplaced");
  c_done: cover property ($rose(load_done));
  c_answer: cover property ($rose(sideband_data_pin_oe));
  c_refused: cover property (mem_ack && !mem_valid);
endmodule // sclsb_props
bind sclsb_top sclsb_props u_props (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
  .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_valid(mem_valid),
  .mem_data(mem_data), .load_done(load_done), .sideband_clock_pin_in(sideband_clock_pin_in),
  .sideband_clock_pin_oe(sideband_clock_pin_oe), .sideband_data_pin_out(sideband_data_pin_out),
  .sideband_data_pin_oe(sideband_data_pin_oe), .port_regs_flat(port_regs_flat));

// File: testbench/test_switch_config_load_and_sideband_access.sv
// self-checking bench of the config loader and sideband slave
`timescale 1ns/100ps
module test_switch_config_load_and_sideband_access;
  logic sys_clk, reset_n, mreq, mack, mval, done, sda, scl, soe, coe, nk, n1;
  logic [7:0] madr, rb;
  logic [15:0] mdat;
  logic [2:0] strap;
  logic [767:0] regs;
  logic [31:0] exp_q[$], got_q[$], rw, wd, g, e;
  logic [11:0] ofs[8] = '{12'h070, 12'h074, 12'h080, 12'h088, 12'h08c, 12'h0d4, 12'h15c, 12'h160};
  string nm_q[$], n;
  int failures = 0, checked = 0, p;
  wire scl_l = scl & ~coe;
  wire sda_l = sda & ~soe;
  sclsb_top dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(1'b1), .mem_req(mreq),
    .mem_addr(madr), .mem_ack(mack), .mem_valid(mval), .mem_data(mdat), .load_done(done),
    .sideband_clock_pin_in(scl_l), .sideband_clock_pin_out(), .sideband_clock_pin_oe(coe),
    .sideband_data_pin_in(sda_l), .sideband_data_pin_out(), .sideband_data_pin_oe(soe),
    .addr_strap(strap), .port_regs_flat(regs));
  sclsb_mem_model mem_u (.sys_clk(sys_clk), .mem_req(mreq), .mem_addr(madr), .mem_ack(mack),
    .mem_valid(mval), .mem_data(mdat));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  function automatic logic [15:0] w(input logic [7:0] a);
    return (a == 8'h94) ? 16'h0 : {a ^ 8'h3c, a};
  endfunction
  // value each register holds once the load is over
  function automatic logic [31:0] ld(input int p, input int k);
    logic [7:0] o;
    logic [15:0] pm, rp, vc, ak;
    o = 8'(2 * p);
    pm = (p == 0) ? 16'h0 : w(8'h80 + o);
    rp = w(8'hd0 + o);
    vc = w(8'hf0 + o);
    ak = w(8'he0 + o);
    case (k)
      0: return {pm[7], ak[14:0], 3'h0, rp[12:0]};
      1: return {17'h0, pm[6:0], 8'h0};
      2: return {w(8'hc0 + o), w(8'hb0 + o)};
      3: return {pm[15:8], 24'h0};
      4: return {6'h0, rp[14:13], 24'h0};
      5: return (p == 0) ? 32'h0 : {w(8'ha0 + o), w(8'h90 + o)};
      6: return {9'h0, vc[6:0], 16'h0};
      default: return {24'h0, vc[15:8]};
    endcase
  endfunction
  task automatic tk(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask
  task automatic note(input string s, input logic [31:0] x);
    nm_q.push_back(s);
    exp_q.push_back(x);
  endtask
  // one sideband bit: 80 ns clock period, data sampled mid high phase
  task automatic bit_io(input logic b, output logic r);
    sda = b;
    tk(2);
    scl = 1'b1;
    tk(2);
    r = sda_l;
    tk(2);
    scl = 1'b0;
    tk(2);
  endtask
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] r, output logic k);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(a, k);
  endtask
  task automatic start();
    sda = 1'b1;
    tk(2);
    scl = 1'b1;
    tk(4);
    sda = 1'b0;
    tk(4);
    scl = 1'b0;
    tk(2);
  endtask
  task automatic stop();
    sda = 1'b0;
    tk(2);
    scl = 1'b1;
    tk(4);
    sda = 1'b1;
    tk(4);
  endtask
  task automatic hdr(input logic [2:0] s, input logic [13:0] a);
    start();
    xfer({4'hd, s, 1'b0}, 1'b1, rb, nk);
    if (nk === 1'b0) begin
      xfer({2'h0, a[13:8]}, 1'b1, rb, n1);
      xfer(a[7:0], 1'b1, rb, n1);
    end
  endtask
  task automatic sb_wr(input logic [2:0] s, input logic [13:0] a, input logic [31:0] d);
    hdr(s, a);
    if (nk === 1'b0) for (int i = 3; i >= 0; i--) xfer(d[8*i +: 8], 1'b1, rb, n1);
    stop();
    got_q.push_back(32'(nk));
  endtask
  task automatic sb_rd(input logic [13:0] a);
    hdr(strap, a);
    start();
    xfer({4'hd, strap, 1'b1}, 1'b1, rb, n1);
    for (int i = 3; i >= 0; i--) xfer(8'hff, i == 0, rw[8*i +: 8], n1);
    stop();
    got_q.push_back(rw);
  endtask
  always @(posedge sys_clk) begin
    while (got_q.size() > 0) begin
      g = got_q.pop_front();
      e = exp_q.pop_front();
      n = nm_q.pop_front();
      checked++;
      if (g !== e) begin
        failures++;
        $display("unexpected %s: expected %h seen %h", n, e, g);
      end
    end
  end
  task automatic test_done();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #400us;
    failures++;
    test_done();
  end
  initial begin
    void'($urandom(31));
    reset_n = 1'b0;
    scl = 1'b1;
    sda = 1'b1;
    strap = 3'($urandom);
    tk(3);
    reset_n = 1'b1;
    note("early nack", 32'h1);
    sb_wr(strap, 14'h070, 32'hffffffff);
    for (int i = 0; i < 3000 && done !== 1'b1; i++) tk(1);
    for (int q = 0; q < 24; q++) begin
      note("loaded", ld(q / 8, q % 8));
      got_q.push_back(regs[(q / 8) * 256 + (q % 8) * 32 +: 32]);
    end
    for (int k = 0; k < 8; k++) begin
      p = $urandom_range(0, 2);
      wd = $urandom;
      note("write ack", 32'h0);
      sb_wr(strap, {p[1:0], ofs[k]}, wd);
      note("read back", wd);
      sb_rd({p[1:0], ofs[k]});
      note("core view", wd);
      got_q.push_back(regs[p * 256 + k * 32 +: 32]);
    end
    note("unmapped ack", 32'h0);
    sb_wr(strap, 14'h07c, wd);
    note("unmapped read", 32'h0);
    sb_rd(14'h07c);
    note("foreign nack", 32'h1);
    sb_wr(strap ^ 3'h1, 14'h070, wd);
    tk(4);
    test_done();
  end
endmodule // test_switch_config_load_and_sideband_access
